// [core/fbs_flash_erase_block_select.sv]
// What this block does
// - erase select clears while write-enable is off
// - several select bits set clears all bits
// - bit 4 picks area 0x1000 to 0x7FFF
// - bits 3..0 pick 1-kbyte areas
// - reserved bits always read zero
// - gate bit set permits flash register access
// - gate bit clear denies flash register access
module fbs_flash_erase_block_select (
   input  wire logic              core_clk,
   input  wire logic              resetn,
   input  wire fbs_pkg::fbs_av_req_s av_req,
   output      fbs_pkg::fbs_av_rsp_s av_rsp,
   output      logic [4:0]        erase_select,
   output      logic              software_write_enable,
   output      fbs_pkg::fbs_area_s erase_area
);
   import fbs_pkg::*;

   // ***************************************************
   // state
   // ***************************************************

   // every register of the block lives in one struct
   fbs_state_s state_reg;
   // value the struct takes at the next edge
   fbs_state_s state_next;

   // ***************************************************
   // helpers
   // ***************************************************

   // true when two or more selection bits are set
   function automatic logic fbs_multi_sel(input logic [7:0] v);
      logic [2:0] cnt;
      cnt = 3'h0;
      // only the five select bits are counted
      for (int i = 0; i < 5; i++) begin
         cnt = cnt + {2'h0, v[i]};
      end
      return cnt > 3'h1;
   endfunction

   // value the erase select register may hold
   function automatic logic [7:0] fbs_legal_sel(input logic [7:0] v,
                                                input logic       software_write_enable_bit);
      logic [7:0] m;
      // reserved bits never reach the register
      m = v & FBS_ERASE_SEL_MASK;
      if (fbs_multi_sel(m)) begin
         m = 8'h00;
      end
      if (!software_write_enable_bit) begin
         m = 8'h00;
      end
      return m;
   endfunction

   // the three words that the gate bit guards
   function automatic logic fbs_is_gated(input logic [3:0] a);
      return (a == FBS_OFS_CTRL_ONE) ||
             (a == FBS_OFS_CTRL_TWO) ||
             (a == FBS_OFS_ERASE_SEL);
   endfunction

   // last address of a 1-kbyte area from its first address
   function automatic logic [14:0] fbs_small_last(input logic [14:0] f);
      return f | FBS_SMALL_SPAN;
   endfunction

   // ***************************************************
   // next state
   // ***************************************************

   // bus timing, one request at a time:
   //   cycle 0: request seen, waitrequest high, read byte captured
   //   cycle 1: waitrequest low, a write lands at the closing edge
   //   cycle 2: a new request waits one state again
   // one-wait-state slave: ack rises the cycle after the request
   always_comb begin
      // scratch values, all set at the top of each pass
      logic       req;
      logic       gated;
      logic       wr;
      logic [7:0] wbyte;
      logic       open_gate;
      req        = 1'b0;
      gated      = 1'b0;
      wr         = 1'b0;
      wbyte      = 8'h00;
      open_gate  = 1'b0;
      // hold every register unless a path below changes it
      state_next = state_reg;
      // only byte lane 0 carries register data
      req   = av_req.read | av_req.write;
      wbyte = av_req.writedata[7:0];
      open_gate = state_reg.access_en[FBS_GATE_BIT];
      // the gate register itself stays reachable
      gated = fbs_is_gated(av_req.address);
      // ack alternates, so a held request is answered every second cycle
      state_next.ack = req & ~state_reg.ack;
      // write takes effect only at the edge where waitrequest is low
      wr = av_req.write & state_reg.ack & av_req.byteenable[0];
      if (wr && (!gated || open_gate)) begin
         case (av_req.address)
            // write-enable sits in bit 6, the rest is storage
            FBS_OFS_CTRL_ONE:  state_next.ctrl_one  = wbyte;
            // plain storage byte
            FBS_OFS_CTRL_TWO:  state_next.ctrl_two  = wbyte;
            FBS_OFS_ERASE_SEL: state_next.erase_sel = wbyte;
            FBS_OFS_ACCESS_EN:
               state_next.access_en = wbyte & FBS_ACCESS_EN_MASK;
            default: ;
         endcase
      end
      // select is cleaned every cycle, so a late swe drop still clears it
      state_next.erase_sel =
         fbs_legal_sel(state_next.erase_sel,
                       state_next.ctrl_one[FBS_SWE_BIT]);
      // read data latched as ack rises; unmapped reads return zero
      state_next.rdata = 32'h0000_0000;
      if (av_req.read && !state_reg.ack && (!gated || open_gate)) begin
         case (av_req.address)
            FBS_OFS_CTRL_ONE:  state_next.rdata[7:0] = state_reg.ctrl_one;
            FBS_OFS_CTRL_TWO:  state_next.rdata[7:0] = state_reg.ctrl_two;
            FBS_OFS_ERASE_SEL:
               state_next.rdata[7:0] = state_reg.erase_sel
                                     & FBS_ERASE_SEL_MASK;
            FBS_OFS_ACCESS_EN:
               state_next.rdata[7:0] = state_reg.access_en
                                     & FBS_ACCESS_EN_MASK;
            default: state_next.rdata = 32'h0000_0000;
         endcase
      end
      state_next.area.valid = |state_next.erase_sel[4:0];
      // no area selected: bounds read as zero
      state_next.area.first = 15'h0000;
      state_next.area.last  = 15'h0000;
      case (state_next.erase_sel[4:0])
         // large block
         5'h10: begin
            state_next.area.first = FBS_LARGE_FIRST;
            state_next.area.last  = FBS_LARGE_LAST;
         end
         // small block three
         5'h08: begin
            state_next.area.first = FBS_SMALL3_FIRST;
            state_next.area.last  = fbs_small_last(FBS_SMALL3_FIRST);
         end
         // small block two
         5'h04: begin
            state_next.area.first = FBS_SMALL2_FIRST;
            state_next.area.last  = fbs_small_last(FBS_SMALL2_FIRST);
         end
         // small block one
         5'h02: begin
            state_next.area.first = FBS_SMALL1_FIRST;
            state_next.area.last  = fbs_small_last(FBS_SMALL1_FIRST);
         end
         // small block zero
         5'h01: begin
            state_next.area.first = FBS_SMALL0_FIRST;
            state_next.area.last  = fbs_small_last(FBS_SMALL0_FIRST);
         end
         // nothing selected: no area
         default: state_next.area.valid = 1'b0;
      endcase
   end

   // ***************************************************
   // state register
   // ***************************************************

   // all state resets to constants
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg.ack        <= 1'b0;
         state_reg.rdata      <= 32'h0000_0000;
         state_reg.ctrl_one   <= FBS_RST_CTRL_ONE;
         state_reg.ctrl_two   <= FBS_RST_CTRL_TWO;
         state_reg.erase_sel  <= FBS_RST_ERASE_SEL;
         state_reg.access_en  <= FBS_RST_ACCESS_EN;
         state_reg.area.valid <= 1'b0;
         state_reg.area.first <= 15'h0000;
         state_reg.area.last  <= 15'h0000;
      end else begin
         // whole struct moves on every edge
         state_reg <= state_next;
      end
   end

   // ***************************************************
   // outputs
   // ***************************************************

   // waitrequest is combinational, data from flops
   assign av_rsp.waitrequest   = (av_req.read | av_req.write)
                               & ~state_reg.ack;
   // read byte stands only in the answer cycle
   assign av_rsp.readdata      = state_reg.rdata;

   // ***************************************************
   // erase outputs
   // ***************************************************

   // select and area move together, one edge after the write
   assign erase_select         = state_reg.erase_sel[4:0];
   // the flash sequencer reads write-enable from here
   assign software_write_enable = state_reg.ctrl_one[FBS_SWE_BIT];
   // area bounds are registered, so no decode glitches leave
   assign erase_area           = state_reg.area;

endmodule // fbs_flash_erase_block_select

// [include/fbs_pkg.sv]
package fbs_pkg;

   // ***************************************************
   // register map (byte addresses, one word each)
   // ***************************************************
   localparam logic [3:0] FBS_OFS_CTRL_ONE    = 4'h0;
   localparam logic [3:0] FBS_OFS_CTRL_TWO    = 4'h4;
   localparam logic [3:0] FBS_OFS_ERASE_SEL   = 4'h8;
   localparam logic [3:0] FBS_OFS_ACCESS_EN   = 4'hC;

   // ***************************************************
   // field positions and masks
   // ***************************************************
   localparam int         FBS_SWE_BIT         = 6;
   localparam int         FBS_GATE_BIT        = 7;
   localparam logic [7:0] FBS_ERASE_SEL_MASK  = 8'h1F;
   localparam logic [7:0] FBS_ACCESS_EN_MASK  = 8'h80;
   localparam int         FBS_LARGE_BIT       = 4;

   // ***************************************************
   // reset values
   // ***************************************************
   localparam logic [7:0] FBS_RST_CTRL_ONE    = 8'h00;
   localparam logic [7:0] FBS_RST_CTRL_TWO    = 8'h00;
   localparam logic [7:0] FBS_RST_ERASE_SEL   = 8'h00;
   localparam logic [7:0] FBS_RST_ACCESS_EN   = 8'h00;

   // ***************************************************
   // erase area bounds
   // ***************************************************
   localparam logic [14:0] FBS_LARGE_FIRST    = 15'h1000;
   localparam logic [14:0] FBS_LARGE_LAST     = 15'h7FFF;
   localparam logic [14:0] FBS_SMALL_SPAN     = 15'h03FF;
   localparam logic [14:0] FBS_SMALL3_FIRST   = 15'h0C00;
   localparam logic [14:0] FBS_SMALL2_FIRST   = 15'h0800;
   localparam logic [14:0] FBS_SMALL1_FIRST   = 15'h0400;
   localparam logic [14:0] FBS_SMALL0_FIRST   = 15'h0000;

   // ***************************************************
   // carriers
   // ***************************************************
   typedef struct packed {
      logic [3:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } fbs_av_req_s;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } fbs_av_rsp_s;

   typedef struct packed {
      logic        valid;
      logic [14:0] first;
      logic [14:0] last;
   } fbs_area_s;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
      logic [7:0]  ctrl_one;
      logic [7:0]  ctrl_two;
      logic [7:0]  erase_sel;
      logic [7:0]  access_en;
      fbs_area_s   area;
   } fbs_state_s;

endpackage // fbs_pkg

// [testbench/fbs_chk.sv]
module fbs_chk (
   input wire logic                 core_clk,
   input wire logic                 resetn,
   input wire fbs_pkg::fbs_av_req_s av_req,
   input wire fbs_pkg::fbs_av_rsp_s av_rsp,
   input wire logic [4:0]           erase_select,
   input wire logic                 software_write_enable,
   input wire fbs_pkg::fbs_area_s   erase_area
);
   timeunit 1ns;
   timeprecision 1ps;
   import fbs_pkg::*;
   logic ack;
   logic gate_reg;
   // completed bus cycle
   assign ack = !av_rsp.waitrequest && (av_req.read || av_req.write);
   // shadow of the gate bit, kept from observed writes
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         gate_reg <= 1'b0;
      else if (ack && av_req.write && av_req.address == 4'hC
               && av_req.byteenable[0])
         gate_reg <= av_req.writedata[7];
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   a_sel_swe_off: assert property (!software_write_enable
      |=> erase_select == 5'h00) else $error("select kept without swe");
   a_sel_onehot: assert property ($onehot0(erase_select))
      else $error("several select bits set");
   a_area_large: assert property (erase_select[4] |-> erase_area.valid
      && erase_area.first == 15'h1000 && erase_area.last == 15'h7FFF)
      else $error("large area wrong");
   a_area_small: assert property (erase_select[3:0] != 4'h0
      |-> erase_area.valid && erase_area.first == {3'h0, erase_select[3]
      | erase_select[2], erase_select[3] | erase_select[1], 10'h000}
      && erase_area.last == (erase_area.first | 15'h03FF))
      else $error("small area wrong");
   a_read_rsvd: assert property (ack && av_req.read
      |-> av_rsp.readdata[31:8] == 24'h0 && (av_req.address != 4'h8
      || av_rsp.readdata[7:5] == 3'h0) && (av_req.address != 4'hC
      || av_rsp.readdata[6:0] == 7'h0)) else $error("reserved bits set");
   a_gate_read: assert property (ack && av_req.read && !gate_reg
      && av_req.address != 4'hC |-> av_rsp.readdata == 32'h0)
      else $error("gated read not zero");
   a_gate_write: assert property (ack && av_req.write && !gate_reg
      && av_req.address == 4'h8 |=> erase_select == 5'h00
      || $stable(erase_select)) else $error("gated write landed");
   a_swe_write: assert property (ack && av_req.write && gate_reg
      && av_req.address == 4'h0 && av_req.byteenable[0]
      |=> software_write_enable == $past(av_req.writedata[6]))
      else $error("write enable not written");
   a_one_wait: assert property ($rose(av_req.read || av_req.write)
      |-> av_rsp.waitrequest ##1 !av_rsp.waitrequest)
      else $error("wait state count wrong");
endmodule // fbs_chk

bind fbs_flash_erase_block_select fbs_chk u_chk (.core_clk(core_clk),
   .resetn(resetn), .av_req(av_req), .av_rsp(av_rsp),
   .erase_select(erase_select), .erase_area(erase_area),
   .software_write_enable(software_write_enable));

// [testbench/tb_flash_erase_block_select.sv]
module tb_flash_erase_block_select;
   timeunit 1ns;
   timeprecision 1ps;
   import fbs_pkg::*;
   logic        core_clk = 0;
   logic        resetn = 0;
   fbs_av_req_s req = '0;
   fbs_av_rsp_s rsp;
   logic [4:0]  sel_o;
   logic        swe_o;
   fbs_area_s   area_o;
   logic [31:0] q, r, seed = 32'hD606CC64;
   int          n_fail = 0, checks = 0, c1 = 0, c2 = 0, sel = 0, gate = 0;
   always #2 core_clk = ~core_clk;
   fbs_flash_erase_block_select dut (.core_clk(core_clk), .resetn(resetn),
      .av_req(req), .av_rsp(rsp), .erase_select(sel_o),
      .software_write_enable(swe_o), .erase_area(area_o));
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // reference read of the register model
   function int mr(input logic [3:0] a);
      case (a)
         4'h0: return gate ? c1 : 0;
         4'h4: return gate ? c2 : 0;
         4'h8: return gate ? sel : 0;
         4'hC: return gate << 7;
         default: return 0;
      endcase
   endfunction
   // reference erase area for the modelled selection
   function logic [30:0] ma();
      for (int k = 0; k < 4; k++) begin
         if (sel == (1 << k))
            return {1'b1, 15'(k * 32'h400), 15'(k * 32'h400 + 32'h3FF)};
      end
      return sel == 16 ? {1'b1, 15'h1000, 15'h7FFF} : 31'h0;
   endfunction
   task tally_and_finish();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one bus cycle, held until waitrequest is seen low; updates the model
   task bus(input logic [3:0] a, input logic w, input logic [7:0] d,
            input logic [3:0] be);
      int n;
      n = 0;
      @(posedge core_clk);
      req <= '{a, !w, w, {24'h0, d}, be};
      do begin
         @(posedge core_clk);
         n++;
      end while (rsp.waitrequest !== 1'b0 && n < 50);
      q = rsp.readdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
      if (n >= 50) begin
         n_fail++;
         tally_and_finish();
      end
      if (w && be[0]) begin
         case (a)
            4'h0: if (gate) c1 = d;
            4'h4: if (gate) c2 = d;
            4'h8: if (gate && c1[6]) sel = d & 8'h1F;
            4'hC: gate = d[7];
            default: ;
         endcase
         if (!c1[6] || $countones(sel) > 1) sel = 0;
      end
   endtask
   // write, read back, compare readback and select outputs
   task rw(input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
      bus(a, 1'b1, d, be);
      bus(a, 1'b0, 8'h00, 4'hF);
      chk(q, mr(a));
      chk({27'h0, sel_o}, sel);
      chk({31'h0, swe_o}, {31'h0, c1[6]});
      chk({1'b0, area_o}, {1'b0, ma()});
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      rw(4'h0, 8'h40, 4'hF);
      rw(4'hC, 8'hFF, 4'hF);
      rw(4'h8, 8'h01, 4'hF);
      rw(4'h4, 8'hAA, 4'hE);
      rw(4'h0, 8'h40, 4'hF);
      $display("test gate done");
      for (int i = 0; i < 5; i++) begin
         rw(4'h8, 8'h01 << i, 4'hF);
         chk(area_o, i == 4 ? {1'b1, 15'h1000, 15'h7FFF} : {1'b1,
            15'(i * 32'h400), 15'(i * 32'h400 + 32'h3FF)});
      end
      rw(4'h8, 8'h03, 4'hF);
      rw(4'h8, 8'h02, 4'hF);
      rw(4'hC, 8'h7F, 4'hF);
      rw(4'h8, 8'h04, 4'hF);
      rw(4'hC, 8'h80, 4'hF);
      rw(4'h0, 8'h00, 4'hF);
      $display("test select done");
      for (int i = 0; i < 60; i++) begin
         r = rnd();
         rw(r[3:0], r[15:8], {r[20:18], r[16] | r[17]});
      end
      $display("test random done");
      // reset in mid-run puts every register back to zero
      resetn <= 1'b0;
      repeat (3) @(posedge core_clk);
      resetn <= 1'b1;
      c1 = 0;
      c2 = 0;
      sel = 0;
      gate = 0;
      rw(4'h0, 8'h40, 4'hF);
      rw(4'hC, 8'h80, 4'hF);
      rw(4'h4, 8'h55, 4'h0);
      rw(4'h0, 8'h40, 4'h0);
      $display("test reset done");
      tally_and_finish();
   end
endmodule // tb_flash_erase_block_select
